// ### core/ivd_pkg.sv
/*
 Shared constants and carrier types of the interrupt and trap dispatch block.
 Assumes a 32-bit classic Wishbone register bus and a single 10 MHz CPU clock.
*/
package ivd_pkg;

  localparam int N_SRC    = 56;
  localparam int N_TRAP   = 9;
  localparam int N_LVL    = 20;
  localparam int ADR_W    = 12;
  localparam int IDX_W    = 6;
  localparam int PRIO_W   = 4;
  localparam int LEVEL_W  = 5;
  localparam int NUM_W    = 8;
  localparam int VEC_W    = 10;

  // Register byte addresses
  localparam logic [ADR_W-1:0] ADR_SRC_BASE = 12'h000;
  localparam logic [ADR_W-1:0] ADR_TFR      = 12'h100;
  localparam logic [ADR_W-1:0] ADR_STATE    = 12'h104;
  localparam logic [ADR_W-1:0] ADR_ISTS     = 12'h108;
  localparam logic [ADR_W-1:0] ADR_IMASK    = 12'h10c;

  // Source control register fields
  localparam int CTL_PRIO_LSB = 0;
  localparam int CTL_EN_BIT   = 6;
  localparam int CTL_REQ_BIT  = 7;

  // State register fields
  localparam int ST_PEND_LSB = 0;
  localparam int ST_TOP_LSB  = 8;
  localparam int ST_SVC_LSB  = 16;

  // Block event bits
  localparam int EV_W     = 2;
  localparam int EV_TRAP  = 0;
  localparam int EV_TAKEN = 1;

  // Trap inputs: class A are bits 0 to 2, class B are bits 3 to 8
  localparam int TR_NMI    = 0;
  localparam int TR_STKOF  = 1;
  localparam int TR_STKUF  = 2;
  localparam int TR_B_LSB  = 3;
  localparam int N_PEND    = 4;
  localparam int PEND_B    = 3;

  localparam logic [NUM_W-1:0]   NUM_NMI   = 8'h02;
  localparam logic [NUM_W-1:0]   NUM_STKOF = 8'h04;
  localparam logic [NUM_W-1:0]   NUM_STKUF = 8'h06;
  localparam logic [NUM_W-1:0]   NUM_CLS_B = 8'h0a;
  localparam logic [LEVEL_W-1:0] LVL_NMI   = 5'h13;
  localparam logic [LEVEL_W-1:0] LVL_STKOF = 5'h12;
  localparam logic [LEVEL_W-1:0] LVL_STKUF = 5'h11;
  localparam logic [LEVEL_W-1:0] LVL_CLS_B = 5'h10;

  // Trap number of each standard source, index 0 in the lowest byte
  localparam logic [N_SRC-1:0][NUM_W-1:0] SRC_NUM = {
    8'h43, 8'h42, 8'h41, 8'h40, 8'h3f, 8'h2f, 8'h2e, 8'h2d, 8'h2c, 8'h2b,
    8'h47, 8'h2a, 8'h29, 8'h28, 8'h27, 8'h26, 8'h25, 8'h24, 8'h23, 8'h22,
    8'h3e, 8'h3d, 8'h21, 8'h20, 8'h46, 8'h45, 8'h44, 8'h3c, 8'h3b, 8'h3a,
    8'h39, 8'h38, 8'h37, 8'h36, 8'h35, 8'h34, 8'h33, 8'h32, 8'h31, 8'h30,
    8'h1f, 8'h1e, 8'h1d, 8'h1c, 8'h1b, 8'h1a, 8'h19, 8'h18, 8'h17, 8'h16,
    8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10};

  typedef struct packed {
    logic              req;
    logic              en;
    logic [PRIO_W-1:0] prio;
  } ivd_src_t;

  typedef struct packed {
    logic               valid;
    logic               is_trap;
    logic [LEVEL_W-1:0] level;
    logic [NUM_W-1:0]   trap_num;
    logic [VEC_W-1:0]   vector;
    logic [IDX_W-1:0]   idx;
  } ivd_offer_t;

endpackage : ivd_pkg

// ### core/ivd_arbiter.sv
/*
 Picks the enabled pending source of highest priority; lowest index wins a tie.
 Assumes registered request and priority inputs on the same clock.
*/
`timescale 1ns/1ps
module ivd_arbiter (
  input  wire logic [ivd_pkg::N_SRC-1:0]                     req_i,
  input  wire logic [ivd_pkg::N_SRC-1:0][ivd_pkg::PRIO_W-1:0] prio_i,
  output logic                                                found_o,
  output logic [ivd_pkg::IDX_W-1:0]                           idx_o,
  output logic [ivd_pkg::PRIO_W-1:0]                          prio_o
);
  import ivd_pkg::*;

  always_comb begin
    found_o = 1'b0;
    idx_o   = '0;
    prio_o  = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (req_i[i] && (!found_o || prio_i[i] >= prio_o)) begin
        found_o = 1'b1;
        idx_o   = IDX_W'(i);
        prio_o  = prio_i[i];
      end
    end
  end

endmodule : ivd_arbiter

// ### core/ivd_top.sv
/*
 Interrupt and hardware trap dispatch with a classic Wishbone register slave.
 Assumes peripheral requests, trap events and CPU handshakes come from logic
 on clk_i as one-cycle pulses; the CPU takes an offer by pulsing cpu_ack_i.
*/
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
// Contract
// - Every source owns a request flag, an enable flag, a vector location and a trap number.
// - A detected exception raises a hardware trap that no software setting can mask.
// - A taken trap sends the CPU to that trap's own vector like an interrupt service; the code gives all six class B traps the one vector of number 0x0a.
// - Each hardware trap also sets its own bit in the trap flag register.
// - A trap pre-empts any program unless a higher trap service runs, then it waits; the code also makes it wait while a trap service of its own level runs.
// - During a trap service no standard interrupt or event transfer may pre-empt.
// - Software gives each source one of sixteen priority levels in its control register.
// - A running interrupt service yields only to a request of strictly higher priority.
`timescale 1ns/1ps
module ivd_top (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [ivd_pkg::ADR_W-1:0]     wb_adr_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic [31:0]                        wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [ivd_pkg::N_SRC-1:0]     src_req_i,
  input  wire logic [ivd_pkg::N_TRAP-1:0]    trap_evt_i,
  input  wire logic                          cpu_ack_i,
  input  wire logic                          cpu_ret_i,
  output ivd_pkg::ivd_offer_t                dispatch_o,
  output logic                               irq_o
);
  import ivd_pkg::*;

  ivd_src_t                     src_reg   [N_SRC];
  ivd_src_t                     src_next  [N_SRC];
  logic [N_SRC-1:0]             cand;
  logic [N_SRC-1:0][PRIO_W-1:0] cand_prio;
  logic                         arb_found;
  logic [IDX_W-1:0]             arb_idx;
  logic [PRIO_W-1:0]            arb_prio;

  logic [N_TRAP-1:0]  trap_flag_register_reg, trap_flag_register_next;
  logic [N_PEND-1:0]  pend_reg, pend_next;
  logic [N_LVL-1:0]   svc_reg, svc_next;
  logic [EV_W-1:0]    ists_reg, ists_next;
  logic [EV_W-1:0]    imask_reg, imask_next;
  ivd_offer_t         offer_reg, offer_next;
  logic               ack_reg, ack_next;
  logic [31:0]        dat_reg, dat_next;
  logic               irq_reg, irq_next;

  logic               acc, wr, hit_src, take;
  logic [IDX_W-1:0]   wr_idx;
  logic [31:0]        wmask, rd;
  logic [LEVEL_W-1:0] top;
  logic               t_found;
  logic [LEVEL_W-1:0] t_lvl;
  logic [NUM_W-1:0]   t_num;
  logic [IDX_W-1:0]   t_idx;

  // Bus decode; a request is answered one cycle after it appears
  assign acc     = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr      = acc && wb_we_i;
  assign hit_src = wb_adr_i[ADR_W-1:2] < (ADR_W-2)'(N_SRC);
  assign wr_idx  = wb_adr_i[IDX_W+1:2];
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign take    = cpu_ack_i && offer_reg.valid;

  // Per-source control: request, enable and priority
  for (genvar g = 0; g < N_SRC; g++) begin : g_src
    always_comb begin
      src_next[g] = src_reg[g];
      if (take && !offer_reg.is_trap && offer_reg.idx == IDX_W'(g)) begin
        src_next[g].req = 1'b0;
      end
      if (wr && hit_src && wr_idx == IDX_W'(g) && wb_sel_i[0]) begin
        src_next[g].req  = wb_dat_i[CTL_REQ_BIT];
        src_next[g].en   = wb_dat_i[CTL_EN_BIT];
        src_next[g].prio = wb_dat_i[CTL_PRIO_LSB +: PRIO_W];
      end
      if (src_req_i[g]) begin
        src_next[g].req = 1'b1;
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        src_reg[g] <= '0;
      end else if (ce_i) begin
        src_reg[g] <= src_next[g];
      end
    end

    assign cand[g]      = src_reg[g].req && src_reg[g].en;
    assign cand_prio[g] = src_reg[g].prio;
  end

  ivd_arbiter u_arb (
    .req_i   (cand),
    .prio_i  (cand_prio),
    .found_o (arb_found),
    .idx_o   (arb_idx),
    .prio_o  (arb_prio)
  );

  always_comb begin
    // Level of the innermost service in progress, zero when idle
    top = '0;
    for (int i = 0; i < N_LVL; i++) begin
      if (svc_reg[i]) begin
        top = LEVEL_W'(i);
      end
    end

    // Trap choice; class A outranks class B, no enable gates them
    t_found = 1'b1;
    t_lvl   = LVL_NMI;
    t_num   = NUM_NMI;
    t_idx   = IDX_W'(TR_NMI);
    if (pend_reg[TR_NMI]) begin
      t_lvl = LVL_NMI;
    end else if (pend_reg[TR_STKOF]) begin
      t_lvl = LVL_STKOF;
      t_num = NUM_STKOF;
      t_idx = IDX_W'(TR_STKOF);
    end else if (pend_reg[TR_STKUF]) begin
      t_lvl = LVL_STKUF;
      t_num = NUM_STKUF;
      t_idx = IDX_W'(TR_STKUF);
    end else if (pend_reg[PEND_B]) begin
      t_lvl = LVL_CLS_B;
      t_num = NUM_CLS_B;
      t_idx = IDX_W'(PEND_B);
    end else begin
      t_found = 1'b0;
    end

    // Offer to the CPU, withdrawn for the cycle after a take
    offer_next = '0;
    if (t_found && t_lvl > top) begin
      offer_next.is_trap  = 1'b1;
      offer_next.level    = t_lvl;
      offer_next.trap_num = t_num;
      offer_next.idx      = t_idx;
      offer_next.valid    = !take;
    end else if (arb_found && {1'b0, arb_prio} > top) begin
      offer_next.level    = {1'b0, arb_prio};
      offer_next.trap_num = SRC_NUM[arb_idx];
      offer_next.idx      = arb_idx;
      offer_next.valid    = !take;
    end
    offer_next.vector = {offer_next.trap_num, 2'b00};

    // Service nesting
    svc_next = svc_reg;
    if (cpu_ret_i) begin
      svc_next[top] = 1'b0;
    end
    if (take) begin
      svc_next[offer_reg.level] = 1'b1;
    end

    // Trap pending: cleared when taken, a new event wins
    pend_next = pend_reg;
    if (take && offer_reg.is_trap) begin
      pend_next[offer_reg.idx[1:0]] = 1'b0;
    end
    pend_next[TR_NMI]   = pend_next[TR_NMI]   | trap_evt_i[TR_NMI];
    pend_next[TR_STKOF] = pend_next[TR_STKOF] | trap_evt_i[TR_STKOF];
    pend_next[TR_STKUF] = pend_next[TR_STKUF] | trap_evt_i[TR_STKUF];
    pend_next[PEND_B]   = pend_next[PEND_B]   | (|trap_evt_i[N_TRAP-1:TR_B_LSB]);

    // Trap flags and block events, write one to clear, set wins
    trap_flag_register_next = trap_flag_register_reg;
    ists_next               = ists_reg;
    imask_next              = imask_reg;
    if (wr && wb_adr_i == ADR_TFR) begin
      trap_flag_register_next = trap_flag_register_reg & ~(wb_dat_i[N_TRAP-1:0]
                                & wmask[N_TRAP-1:0]);
    end
    if (wr && wb_adr_i == ADR_ISTS) begin
      ists_next = ists_reg & ~(wb_dat_i[EV_W-1:0] & wmask[EV_W-1:0]);
    end
    if (wr && wb_adr_i == ADR_IMASK && wb_sel_i[0]) begin
      imask_next = wb_dat_i[EV_W-1:0];
    end
    trap_flag_register_next = trap_flag_register_next | trap_evt_i;
    ists_next[EV_TRAP]      = ists_next[EV_TRAP] | (|trap_evt_i);
    ists_next[EV_TAKEN]     = ists_next[EV_TAKEN] | take;
    irq_next                = |(ists_reg & imask_reg);

    // Read data; unmapped addresses read zero
    rd = '0;
    if (hit_src) begin
      rd[CTL_PRIO_LSB +: PRIO_W] = src_reg[wr_idx].prio;
      rd[CTL_EN_BIT]             = src_reg[wr_idx].en;
      rd[CTL_REQ_BIT]            = src_reg[wr_idx].req;
    end else if (wb_adr_i == ADR_TFR) begin
      rd[N_TRAP-1:0] = trap_flag_register_reg;
    end else if (wb_adr_i == ADR_STATE) begin
      rd[ST_PEND_LSB +: N_PEND] = pend_reg;
      rd[ST_TOP_LSB +: LEVEL_W] = top;
      rd[$bits(rd)-1:ST_SVC_LSB] = svc_reg[$bits(rd)-1-ST_SVC_LSB:0];
    end else if (wb_adr_i == ADR_ISTS) begin
      rd[EV_W-1:0] = ists_reg;
    end else if (wb_adr_i == ADR_IMASK) begin
      rd[EV_W-1:0] = imask_reg;
    end
    ack_next = acc;
    dat_next = (acc && !wb_we_i) ? rd : '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_flag_register_reg <= '0;
      pend_reg               <= '0;
      svc_reg                <= '0;
      ists_reg               <= '0;
      imask_reg              <= '0;
      offer_reg              <= '0;
      ack_reg                <= 1'b0;
      dat_reg                <= '0;
      irq_reg                <= 1'b0;
    end else if (ce_i) begin
      trap_flag_register_reg <= trap_flag_register_next;
      pend_reg               <= pend_next;
      svc_reg                <= svc_next;
      ists_reg               <= ists_next;
      imask_reg              <= imask_next;
      offer_reg              <= offer_next;
      ack_reg                <= ack_next;
      dat_reg                <= dat_next;
      irq_reg                <= irq_next;
    end
  end

  assign wb_dat_o   = dat_reg;
  assign wb_ack_o   = ack_reg;
  assign dispatch_o = offer_reg;
  assign irq_o      = irq_reg;

endmodule : ivd_top

// ### dv/ivd_chk.sv
/*
 Checker of the dispatch offer, the CPU handshake and the register bus answer.
 Assumes it is bound to ivd_top and sees only its ports.
*/
`timescale 1ns/1ps
module ivd_chk (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       ce_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic [ivd_pkg::N_TRAP-1:0] trap_evt_i,
  input wire logic                       cpu_ack_i,
  input wire logic                       cpu_ret_i,
  input ivd_pkg::ivd_offer_t             dispatch_o
);
  import ivd_pkg::*;
  logic [N_LVL-1:0]   svc_reg;
  logic [N_LVL-1:0]   svc_next;
  logic [LEVEL_W-1:0] top;
  logic               take;
  // Service levels in progress, as the CPU sees them
  always_comb begin
    take = ce_i && cpu_ack_i && dispatch_o.valid;
    top = '0;
    for (int i = 0; i < N_LVL; i++) if (svc_reg[i]) top = 5'(i);
    svc_next = svc_reg;
    if (ce_i && cpu_ret_i) svc_next[top] = 1'b0;
    if (take) svc_next[dispatch_o.level] = 1'b1;
  end
  always_ff @(posedge clk_i) begin
    svc_reg <= rst_i ? '0 : svc_next;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_vec_four: assert property (
    dispatch_o.valid |-> dispatch_o.vector == {dispatch_o.trap_num, 2'b00})
    else $error("vector is not four times the number");
  chk_src_num: assert property (
    dispatch_o.valid && !dispatch_o.is_trap |->
      dispatch_o.level < 5'h10 && dispatch_o.trap_num == SRC_NUM[dispatch_o.idx])
    else $error("interrupt offer with wrong number or level");
  chk_higher_only: assert property (dispatch_o.valid |-> dispatch_o.level > top)
    else $error("offer not above current service level");
  chk_trap_blocks: assert property (
    dispatch_o.valid && !dispatch_o.is_trap |-> top < LVL_CLS_B)
    else $error("interrupt offered during trap service");
  chk_take_drop: assert property (take |=> !dispatch_o.valid)
    else $error("offer still valid after take");
  chk_nmi_offer: assert property (
    ce_i && trap_evt_i[TR_NMI] && !svc_reg[LVL_NMI] && !take ##1 ce_i && !cpu_ack_i
      |=> dispatch_o.valid && dispatch_o.is_trap && dispatch_o.level == LVL_NMI)
    else $error("non-maskable trap not offered");
  chk_clsb_num: assert property (
    dispatch_o.valid && dispatch_o.is_trap |-> dispatch_o.level >= LVL_CLS_B &&
      (dispatch_o.level != LVL_CLS_B || dispatch_o.trap_num == NUM_CLS_B))
    else $error("trap offer with wrong level or number");
  cover property (take && dispatch_o.is_trap);
  cover property (take && !dispatch_o.is_trap && top != 5'h0);
  cover property (take && dispatch_o.level == LVL_NMI && top == LVL_CLS_B);
endmodule : ivd_chk

bind ivd_top ivd_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .trap_evt_i(trap_evt_i), .cpu_ack_i(cpu_ack_i),
  .cpu_ret_i(cpu_ret_i), .dispatch_o(dispatch_o));

// ### dv/ivd_cpu_model.sv
/*
 CPU core model: takes each offer after slow_i cycles and keeps the last one.
 Assumes the dispatch offer and this model share clk_i.
*/
`timescale 1ns/1ps
module ivd_cpu_model (
  input wire logic           clk_i,
  input wire logic           rst_i,
  input ivd_pkg::ivd_offer_t dispatch_i,
  input wire logic [3:0]     slow_i,
  output logic               cpu_ack_o,
  output ivd_pkg::ivd_offer_t last_o,
  output logic [7:0]         n_taken_o
);
  import ivd_pkg::*;
  logic [3:0] cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_ack_o <= 1'b0;
      cnt       <= '0;
      n_taken_o <= '0;
      last_o    <= '0;
    end else begin
      cpu_ack_o <= 1'b0;
      if (cpu_ack_o && dispatch_i.valid) begin
        last_o    <= dispatch_i;
        n_taken_o <= n_taken_o + 8'h01;
        cnt       <= '0;
      end else if (dispatch_i.valid && !cpu_ack_o) begin
        if (cnt >= slow_i) cpu_ack_o <= 1'b1;
        else cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : ivd_cpu_model

// ### dv/ivd_top_tb.sv
/*
 Testbench of ivd_top: bus tasks, request pulses and the CPU model.
 Assumes a 100 ns clock and the checker bound beside the design.
*/
`timescale 1ns/1ps
module ivd_top_tb;
  import ivd_pkg::*;
  logic clk_i, rst_i, ce_i, cyc, stb, we, ack, ret, wb_ack_o, irq_o;
  logic [3:0]  sel, slow;
  logic [11:0] adr;
  logic [31:0] dat, wb_dat_o, q;
  logic [55:0] src;
  logic [8:0]  trp;
  logic [7:0]  n_taken;
  ivd_offer_t  offer, last;
  int n_fail, comparisons, cycles;

  ivd_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .src_req_i(src), .trap_evt_i(trp), .cpu_ack_i(ack),
    .cpu_ret_i(ret), .dispatch_o(offer), .irq_o(irq_o));
  ivd_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .dispatch_i(offer), .slow_i(slow),
    .cpu_ack_o(ack), .last_o(last), .n_taken_o(n_taken));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask : acc
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    check(what, q, e);
  endtask : rd_chk
  task automatic pulse(input logic [55:0] s, input logic [8:0] t, input logic r);
    @(posedge clk_i);
    {src, trp, ret} <= {s, t, r};
    @(posedge clk_i);
    {src, trp, ret} <= '0;
  endtask : pulse
  task automatic take_chk(input logic [9:0] v, input logic [7:0] n, input logic [4:0] l);
    logic [7:0] n0;
    n0 = n_taken;
    for (int i = 0; i < 40 && n_taken == n0; i++) @(posedge clk_i);
    check("taken", 32'(n_taken), 32'(n0 + 8'h01));
    check("vector", 32'(last.vector), 32'(v));
    check("number", 32'(last.trap_num), 32'(n));
    check("level", 32'(last.level), 32'(l));
    check("trap kind", 32'(last.is_trap), 32'(l >= LVL_CLS_B));
  endtask : take_chk
  task automatic idle_chk(input string what);
    logic [7:0] n0;
    n0 = n_taken;
    repeat (12) @(posedge clk_i);
    check(what, 32'(n_taken), 32'(n0));
  endtask : idle_chk
  task give_verdict;
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    {rst_i, ce_i, cyc, stb, we, ret} = 6'h30;
    adr = '0;
    dat = '0;
    src = '0;
    trp = '0;
    slow = '0;
    sel = 4'hf;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl6 reset", 12'h018, 32'h0);
    rd_chk("unmapped", 12'h200, 32'h0);
    slow <= 4'h3;
    acc(1'b1, 12'h018, 32'h45);
    acc(1'b1, 12'h01c, 32'h45);
    acc(1'b1, 12'h020, 32'h49);
    pulse(56'h40, 9'h0, 1'b0);
    take_chk(10'h058, 8'h16, 5'h05);
    rd_chk("ctrl6 taken", 12'h018, 32'h45);
    rd_chk("state", 12'h104, 32'h00200500);
    slow <= 4'h0;
    pulse(56'h180, 9'h0, 1'b0);
    take_chk(10'h060, 8'h18, 5'h09);
    pulse(56'h0, 9'h0, 1'b1);
    idle_chk("equal level");
    pulse(56'h0, 9'h0, 1'b1);
    take_chk(10'h05c, 8'h17, 5'h05);
    pulse(56'h0, 9'h0, 1'b1);
    pulse(56'h0, 9'h008, 1'b0);
    take_chk(10'h028, 8'h0a, 5'h10);
    pulse(56'h100, 9'h0, 1'b0);
    idle_chk("irq in trap");
    pulse(56'h0, 9'h001, 1'b0);
    take_chk(10'h008, 8'h02, 5'h13);
    pulse(56'h0, 9'h010, 1'b0);
    idle_chk("lower trap");
    pulse(56'h0, 9'h0, 1'b1);
    pulse(56'h0, 9'h0, 1'b1);
    take_chk(10'h028, 8'h0a, 5'h10);
    pulse(56'h0, 9'h0, 1'b1);
    take_chk(10'h060, 8'h18, 5'h09);
    pulse(56'h0, 9'h0, 1'b1);
    rd_chk("trap flags", 12'h100, 32'h19);
    acc(1'b1, 12'h100, 32'h1ff);
    rd_chk("trap flags clear", 12'h100, 32'h0);
    rd_chk("status", 12'h108, 32'h3);
    check("irq masked", 32'(irq_o), 32'h0);
    acc(1'b1, 12'h10c, 32'h1);
    repeat (2) @(posedge clk_i);
    check("irq on", 32'(irq_o), 32'h1);
    acc(1'b1, 12'h108, 32'h3);
    repeat (2) @(posedge clk_i);
    check("irq off", 32'(irq_o), 32'h0);
    rd_chk("status clear", 12'h108, 32'h0);
    ce_i <= 1'b0;
    pulse(56'h40, 9'h0, 1'b0);
    ce_i <= 1'b1;
    idle_chk("frozen request");
    give_verdict();
  end
endmodule : ivd_top_tb
